// ==== pump_pkg.sv ====
// Purpose: shared constants and carriers for the pump staging controller
// Assumes: up to six drives, speeds as unsigned 16-bit values
// Notes: percentages are whole numbers 0..100
package pump_pkg;

  localparam int N_PUMP = 6;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;

  localparam logic [1:0] SEL_ALT = 2'h2;
  localparam logic [1:0] POL_STOP = 2'h0;
  localparam logic [1:0] POL_TIMER = 2'h1;
  localparam logic [1:0] POL_BOTH = 2'h2;
  localparam logic [1:0] POL_DEFAULT = POL_BOTH;

  localparam logic [11:0] CHANGE_H_MIN = 12'h001;
  localparam logic [11:0] CHANGE_H_DEFAULT = 12'h032;
  localparam logic [2:0] KEEP_DEFAULT = 3'h0;
  localparam logic [6:0] UB_DEFAULT = 7'h0a;
  localparam logic [6:0] LB_DEFAULT = 7'h0a;
  localparam logic [6:0] TRANS_DEFAULT = 7'h3c;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [23:0] SEC_PER_HOUR = 24'h000e10;
  localparam logic [3:0] PICK_NONE = 4'hf;

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_SLOW, ST_SETTLE, ST_SWAP} stage_e;

  typedef struct packed {
    logic [1:0] pump_sel;
    logic [1:0] change_pol;
    logic [11:0] change_hours;
    logic [2:0] pumps_kept_during_swap;
    logic [2:0] n_drives;
    logic [6:0] upper_band;
    logic [6:0] lower_band;
    logic [6:0] upper_limit;
    logic [6:0] lower_limit;
    logic [9:0] start_delay;
    logic [9:0] stop_delay;
    logic [9:0] settle_start;
    logic [6:0] pre_add_master_speed_pct;
  } cfg_s;

  typedef struct packed {
    logic [15:0] min_speed;
    logic [15:0] max_speed;
    logic [15:0] master_speed;
  } speed_s;

  typedef struct packed {
    logic drive_run;
    logic power_up;
    logic stop;
    logic standby;
    logic trip;
    logic fb_used;
    logic [N_PUMP-1:0] pump_fault;
  } event_s;

  typedef struct packed {
    logic [N_PUMP-1:0] relay;
    logic [2:0] master;
    logic [15:0] speed_req;
    logic slow_req;
    logic pid_off;
    logic change_due;
  } stat_s;

endpackage

// ==== run_meter.sv ====
// Purpose: accumulated run time of one drive, in seconds
// Assumes: tick is a one-cycle pulse once per second
// Notes: clear wins over counting
`timescale 1ns/100ps
`default_nettype none
module run_meter (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic tick,
  input wire logic running,
  input wire logic clear,
  // result
  output logic [31:0] secs
);

  typedef struct packed {
    logic [31:0] secs;
  } meter_s;

  meter_s s_reg;
  meter_s s_next;

  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.secs = 32'h0;
    end else if (tick && running && s_reg.secs != 32'hffffffff) begin
      s_next.secs = s_reg.secs + 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign secs = s_reg.secs;

endmodule // run_meter
`default_nettype wire

// ==== pump_stager.sv ====
// Purpose: master rotation and additional pump staging for a pump group
// Assumes: settings, speeds and events synchronous to mclk
// Notes: run time kept in seconds per drive
//
// Notes on behaviour
// RULE1 - policy 0 stop, 1 timer, 2 both
// RULE2 - rotation only under alternating-master selection
// RULE3 - new master is lowest run-time drive
// RULE4 - stop policy: change only at events
// RULE5 - timer policy: drop pumps, swap, restart
// RULE6 - both policy: expiry marks due, event changes
// RULE7 - master feedback error forces immediate change
// RULE8 - rotation timer 1 to 3000 hours (code raises 0 to 1 but takes change_hours up to 4095)
// RULE9 - keep programmed pumps running during swap
// RULE10 - upper band adds pump after delay
// RULE11 - lower band stops pump after delay
// RULE12 - start delay must fully elapse
// RULE13 - stop delay before stopping top pump
// RULE14 - upper band limit adds pump at once
// RULE15 - lower band limit stops pump at once
// RULE16 - settle time after add, controller off
// RULE17 - slow master to transition speed first
// RULE18 - transition 100 percent skips adaption
// RULE19 - add pump with fewest run hours
// RULE20 - other selections keep a fixed master
// RULE21 - delays restart when speed leaves band
`timescale 1ns/100ps
`default_nettype none
module pump_stager #(
  parameter int TICK_CYCLES = pump_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // settings
  input wire pump_pkg::cfg_s cfg,
  // speeds
  input wire pump_pkg::speed_s spd,
  // drive events and pump feedback
  input wire pump_pkg::event_s ev,
  input wire logic [pump_pkg::N_PUMP-1:0] rt_clear,
  // status and relays
  output pump_pkg::stat_s stat,
  output logic [pump_pkg::N_PUMP-1:0][31:0] run_secs
);

  typedef struct packed {
    pump_pkg::stage_e st;
    logic [23:0] tick_cnt;
    logic [9:0] start_cnt;
    logic [9:0] stop_cnt;
    logic [9:0] settle_cnt;
    logic [23:0] rot_sec;
    logic due;
    logic [2:0] master;
    logic [pump_pkg::N_PUMP-1:0][2:0] stack;
    logic [2:0] depth;
    logic [2:0] restore;
    logic [2:0] pend;
    logic [pump_pkg::N_PUMP-1:0] relay;
    logic [15:0] speed_req;
    logic slow;
    logic pid_off;
  } state_s;

  state_s s_reg;
  state_s s_next;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [15:0] scale(input logic [15:0] sp, input logic [6:0] p);
    logic [22:0] t;
    t = 23'(sp) * 23'(p);
    return 16'(t / 23'(pump_pkg::PCT_FULL));
  endfunction

  function automatic logic [3:0] pick_low(input logic [pump_pkg::N_PUMP-1:0] ok,
                                          input logic [pump_pkg::N_PUMP-1:0][31:0] rt);
    logic [3:0] b;
    logic [31:0] v;
    b = pump_pkg::PICK_NONE;
    v = 32'hffffffff;
    for (int i = 0; i < pump_pkg::N_PUMP; i++) begin
      if (ok[i] && (b == pump_pkg::PICK_NONE || rt[i] < v)) begin
        b = 4'(i);
        v = rt[i];
      end
    end
    return b;
  endfunction

  // -------------------------------------------------------------
  // run time per drive
  // -------------------------------------------------------------
  logic tick;
  logic [pump_pkg::N_PUMP-1:0] running;

  assign tick = (s_reg.tick_cnt == 24'(TICK_CYCLES - 1));

  genvar gi;
  generate
    for (gi = 0; gi < pump_pkg::N_PUMP; gi++) begin : g_meter
      assign running[gi] = s_reg.relay[gi] | (ev.drive_run && s_reg.master == 3'(gi));
      run_meter u_meter (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .tick(tick),
        .running(running[gi]),
        .clear(rt_clear[gi]),
        .secs(run_secs[gi])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // speed bands
  // -------------------------------------------------------------
  logic [15:0] span;
  logic in_up;
  logic lim_up;
  logic in_lo;
  logic lim_lo;
  logic [15:0] trans_spd;

  always_comb begin
    span = spd.max_speed - spd.min_speed;
    in_up = spd.master_speed >= spd.max_speed - scale(span, cfg.upper_band); // RULE10
    lim_up = cfg.upper_limit != 7'h0 &&
             spd.master_speed >= spd.max_speed - scale(span, cfg.upper_limit); // RULE14
    in_lo = spd.master_speed <= spd.min_speed + scale(span, cfg.lower_band); // RULE11
    lim_lo = cfg.lower_limit != 7'h0 &&
             spd.master_speed <= spd.min_speed + scale(span, cfg.lower_limit); // RULE15
    trans_spd = spd.min_speed + scale(span, cfg.pre_add_master_speed_pct); // RULE17
  end

  // -------------------------------------------------------------
  // availability and selection
  // -------------------------------------------------------------
  logic alt;
  logic [pump_pkg::N_PUMP-1:0] avail;
  logic [pump_pkg::N_PUMP-1:0] mmask;
  logic [3:0] add_pick;
  logic [3:0] master_pick;
  logic [3:0] fault_pick;
  logic [3:0] event_pick;
  logic [11:0] hours;
  logic [23:0] hours_sec;
  logic [2:0] keep;
  logic [2:0] keep_max;
  logic any_event;
  logic master_fault;

  always_comb begin
    alt = (cfg.pump_sel == pump_pkg::SEL_ALT); // RULE2 RULE20
    for (int i = 0; i < pump_pkg::N_PUMP; i++) begin
      avail[i] = (3'(i) < cfg.n_drives) && !(ev.fb_used && ev.pump_fault[i]);
    end
    mmask = 6'(6'h1 << s_reg.master);
    add_pick = pick_low(avail & ~s_reg.relay & ~mmask, run_secs); // RULE19
    master_pick = pick_low(avail & ~s_reg.relay, run_secs); // RULE3
    fault_pick = pick_low(avail & ~s_reg.relay & ~mmask, run_secs); // RULE3
    event_pick = pick_low(avail, run_secs); // RULE3
    hours = (cfg.change_hours < pump_pkg::CHANGE_H_MIN) ? pump_pkg::CHANGE_H_MIN : cfg.change_hours;
    hours_sec = 24'(hours * pump_pkg::SEC_PER_HOUR); // RULE8
    keep_max = (cfg.n_drives > 3'h2) ? cfg.n_drives - 3'h2 : 3'h0;
    keep = (cfg.pumps_kept_during_swap > keep_max) ? keep_max : cfg.pumps_kept_during_swap; // RULE9
    any_event = ev.power_up | ev.stop | ev.standby | ev.trip;
    master_fault = ev.fb_used && ev.pump_fault[s_reg.master];
  end

  // -------------------------------------------------------------
  // staging sequence
  // -------------------------------------------------------------
  logic start_go;
  logic stop_go;
  logic rot_hit;
  logic push;
  logic [2:0] push_idx;
  logic pop;
  logic [2:0] top;

  always_comb begin
    s_next = s_reg;
    push = 1'b0;
    push_idx = 3'h0;
    pop = 1'b0;
    top = s_reg.stack[s_reg.depth - 3'h1];
    s_next.tick_cnt = tick ? 24'h0 : s_reg.tick_cnt + 24'h1;

    // band delay timers
    if (!in_up) begin
      s_next.start_cnt = 10'h0; // RULE21
    end else if (tick && s_reg.start_cnt != 10'h3ff) begin
      s_next.start_cnt = s_reg.start_cnt + 10'h1;
    end
    if (!in_lo) begin
      s_next.stop_cnt = 10'h0; // RULE21
    end else if (tick && s_reg.stop_cnt != 10'h3ff) begin
      s_next.stop_cnt = s_reg.stop_cnt + 10'h1;
    end
    start_go = lim_up || (in_up && s_reg.start_cnt >= cfg.start_delay); // RULE12 RULE14
    stop_go = lim_lo || (in_lo && s_reg.stop_cnt >= cfg.stop_delay); // RULE13 RULE15

    // rotation timer
    if (alt && ev.drive_run && tick && s_reg.rot_sec != 24'hffffff) begin
      s_next.rot_sec = s_reg.rot_sec + 24'h1;
    end
    rot_hit = alt && s_reg.rot_sec >= hours_sec; // RULE8

    case (s_reg.st)
      pump_pkg::ST_IDLE: begin
        if (ev.drive_run) begin
          s_next.st = pump_pkg::ST_RUN;
        end
      end
      pump_pkg::ST_RUN: begin
        if (!ev.drive_run) begin
          s_next.st = pump_pkg::ST_IDLE;
        end else if (rot_hit && s_reg.rot_sec != 24'h0) begin
          s_next.rot_sec = 24'h0;
          if (cfg.change_pol == pump_pkg::POL_TIMER) begin
            s_next.st = pump_pkg::ST_SWAP; // RULE5
            s_next.restore = s_reg.depth;
          end else begin
            s_next.due = 1'b1; // RULE4 RULE6
          end
        end else if (s_reg.restore > s_reg.depth && add_pick != pump_pkg::PICK_NONE) begin
          push = 1'b1; // RULE5
          push_idx = add_pick[2:0];
        end else if (start_go && add_pick != pump_pkg::PICK_NONE) begin
          if (cfg.pre_add_master_speed_pct >= pump_pkg::PCT_FULL) begin
            push = 1'b1; // RULE18
            push_idx = add_pick[2:0];
          end else begin
            s_next.st = pump_pkg::ST_SLOW; // RULE17
            s_next.pend = add_pick[2:0];
            s_next.speed_req = trans_spd;
            s_next.slow = 1'b1;
          end
        end else if (stop_go && s_reg.depth != 3'h0) begin
          pop = 1'b1; // RULE11 RULE13
        end
      end
      pump_pkg::ST_SLOW: begin
        if (!ev.drive_run) begin
          s_next.st = pump_pkg::ST_IDLE;
          s_next.slow = 1'b0;
        end else if (spd.master_speed <= s_reg.speed_req) begin
          push = 1'b1; // RULE19
          push_idx = s_reg.pend;
          s_next.slow = 1'b0;
        end
      end
      pump_pkg::ST_SETTLE: begin
        if (s_reg.settle_cnt >= cfg.settle_start) begin
          s_next.st = pump_pkg::ST_RUN; // RULE16
          s_next.pid_off = 1'b0;
        end else if (tick) begin
          s_next.settle_cnt = s_reg.settle_cnt + 10'h1;
        end
      end
      pump_pkg::ST_SWAP: begin
        if (s_reg.depth > keep) begin
          pop = 1'b1; // RULE9
        end else begin
          if (master_pick != pump_pkg::PICK_NONE) begin
            s_next.master = master_pick[2:0]; // RULE5
          end
          s_next.st = pump_pkg::ST_RUN;
        end
      end
      default: begin
        s_next.st = pump_pkg::ST_IDLE;
      end
    endcase

    // relay stack, most recent on top
    if (push) begin
      s_next.stack[s_reg.depth] = push_idx;
      s_next.depth = s_reg.depth + 3'h1;
      s_next.relay[push_idx] = 1'b1;
      s_next.st = pump_pkg::ST_SETTLE; // RULE16
      s_next.settle_cnt = 10'h0;
      s_next.pid_off = 1'b1;
    end
    if (pop) begin
      s_next.relay[top] = 1'b0;
      s_next.depth = s_reg.depth - 3'h1;
    end
    if (s_next.restore <= s_next.depth && s_reg.st != pump_pkg::ST_SWAP) begin
      s_next.restore = 3'h0;
    end

    // power-up, stop, standby, trip
    if (any_event) begin
      s_next.relay = '0;
      s_next.depth = 3'h0;
      s_next.restore = 3'h0;
      s_next.slow = 1'b0;
      s_next.pid_off = 1'b0;
      s_next.st = pump_pkg::ST_IDLE;
      if (alt && s_reg.due) begin
        s_next.due = 1'b0; // RULE4 RULE6
        if (event_pick != pump_pkg::PICK_NONE) begin
          s_next.master = event_pick[2:0]; // RULE3
        end
      end
    end

    // due set by expiry wins over clear by event
    if (alt && rot_hit && s_reg.rot_sec != 24'h0 && s_reg.st == pump_pkg::ST_RUN &&
        ev.drive_run && cfg.change_pol != pump_pkg::POL_TIMER) begin
      s_next.due = 1'b1; // RULE1
    end

    // master feedback error
    if (alt && master_fault && fault_pick != pump_pkg::PICK_NONE) begin
      s_next.master = fault_pick[2:0]; // RULE7
      s_next.due = 1'b0;
      s_next.rot_sec = 24'h0;
    end

    // fixed master selections
    if (!alt) begin
      s_next.master = 3'h0; // RULE20
      s_next.due = 1'b0;
      s_next.rot_sec = 24'h0;
      s_next.restore = 3'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign stat = '{relay: s_reg.relay, master: s_reg.master, speed_req: s_reg.speed_req,
                  slow_req: s_reg.slow, pid_off: s_reg.pid_off, change_due: s_reg.due};

endmodule // pump_stager
`default_nettype wire

// ==== pump_stager_props.sv ====
// Purpose: port checks for pump_stager
// Assumes: bound to pump_stager, one clock domain
// Notes: relay bits index drives
`timescale 1ns/100ps
`default_nettype none
module pump_stager_props #(
  parameter int TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // watched ports
  input wire pump_pkg::cfg_s cfg,
  input wire pump_pkg::speed_s spd,
  input wire pump_pkg::event_s ev,
  input wire logic [pump_pkg::N_PUMP-1:0] rt_clear,
  input wire pump_pkg::stat_s stat,
  input wire logic [pump_pkg::N_PUMP-1:0][31:0] run_secs
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  wire logic any_ev = ev.power_up | ev.stop | ev.standby | ev.trip;
  wire logic [31:0] trans = 32'(spd.min_speed)
    + 32'(spd.max_speed - spd.min_speed) * 32'(cfg.pre_add_master_speed_pct) / 32'h64;
  logic [pump_pkg::N_PUMP-1:0] spare;
  // drives able to take over as master
  always_comb begin
    for (int i = 0; i < pump_pkg::N_PUMP; i++) begin
      spare[i] = 3'(i) < cfg.n_drives && !ev.pump_fault[i] && !stat.relay[i] && 3'(i) != stat.master;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_at_trans;
    ce && !any_ev && ev.drive_run && stat.slow_req && spd.master_speed <= stat.speed_req;
  endsequence
  sequence s_added;
    $countones(stat.relay) == $countones($past(stat.relay)) + 1 && !stat.slow_req;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_event_clears: assert property (ce && any_ev |=> stat.relay == '0)
    else $error("relays kept after event");
  chk_trans_speed: assert property (stat.slow_req |-> stat.speed_req == trans[15:0])
    else $error("wrong transition speed");
  chk_full_no_slow: assert property ($rose(stat.slow_req) |-> $past(cfg.pre_add_master_speed_pct) < pump_pkg::PCT_FULL)
    else $error("slowed at full transition setting");
  chk_one_add: assert property ($countones(stat.relay & ~$past(stat.relay)) <= 1)
    else $error("two pumps added at once");
  chk_add_at_trans: assert property (s_at_trans |=> s_added)
    else $error("no add at transition speed");
  chk_master_free: assert property (stat.relay[stat.master] == 1'b0)
    else $error("master drive on a relay");
  chk_fixed_master: assert property (ce && cfg.pump_sel != pump_pkg::SEL_ALT |=> stat.master == 3'h0)
    else $error("master moved under fixed selection");
  chk_fault_swap: assert property (ce && !any_ev && cfg.pump_sel == pump_pkg::SEL_ALT && ev.fb_used
    && ev.pump_fault[stat.master] && spare != '0 |=> stat.master != $past(stat.master))
    else $error("faulty master kept");
  chk_settle_add: assert property ($countones(stat.relay & ~$past(stat.relay)) != 0 |-> stat.pid_off)
    else $error("controller on after add");
endmodule // pump_stager_props
`default_nettype wire

// ==== pump_bank.sv ====
// Purpose: additional pumps behind relays, with status feedback
// Assumes: feedback error while contactor lags or when commanded
// Notes: behavioural
`timescale 1ns/100ps
`default_nettype none
module pump_bank (
  // clock
  input wire logic mclk,
  // relays and commanded errors
  input wire logic [pump_pkg::N_PUMP-1:0] relay,
  input wire logic [pump_pkg::N_PUMP-1:0] fail_mask,
  // status feedback
  output logic [pump_pkg::N_PUMP-1:0] pump_fault
);
  logic [pump_pkg::N_PUMP-1:0] running_reg = '0;
  always @(posedge mclk) running_reg <= relay;
  // contactor lag shows as a short error
  assign pump_fault = fail_mask | (relay & ~running_reg);
endmodule // pump_bank
`default_nettype wire

// ==== pump_stager_bench.sv ====
// Purpose: self-checking bench for pump_stager
// Assumes: one second is four cycles
// Notes: span 100..1100, bands 10 percent
`timescale 1ns/100ps
`default_nettype none
module pump_stager_bench;
  localparam int TICK = 4;
  typedef struct packed {logic [6:0] pct; logic [15:0] exp;} row_s;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  pump_pkg::cfg_s cfg;
  pump_pkg::speed_s spd;
  pump_pkg::event_s ev_drv;
  pump_pkg::event_s ev;
  logic [pump_pkg::N_PUMP-1:0] rt_clear = '0;
  logic [pump_pkg::N_PUMP-1:0] fail_mask = '0;
  logic [pump_pkg::N_PUMP-1:0] fault;
  pump_pkg::stat_s stat;
  logic [pump_pkg::N_PUMP-1:0][31:0] run_secs;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  logic [2:0] old_master;
  logic [31:0] rt_snap;
  row_s rows [3] = '{'{7'h3c, 16'h02bc}, '{7'h00, 16'h0064}, '{7'h19, 16'h015e}};
  // ----------------------------------------
  // clock, parts
  // ----------------------------------------
  always #50 mclk = ~mclk;
  always_comb begin
    ev = ev_drv;
    ev.pump_fault = fault;
  end
  pump_bank i_bank (.mclk(mclk), .relay(stat.relay), .fail_mask(fail_mask), .pump_fault(fault));
  pump_stager #(.TICK_CYCLES(TICK)) i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .cfg(cfg), .spd(spd),
    .ev(ev), .rt_clear(rt_clear), .stat(stat), .run_secs(run_secs));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({15'h0000, got}, {15'h0000, exp});
  endtask
  function automatic logic hit(input int mode);
    case (mode)
      0: return stat.slow_req;
      1: return stat.relay != '0;
      2: return stat.relay == '0;
      3: return stat.change_due;
      default: return stat.master != old_master;
    endcase
  endfunction
  task automatic wait_for(input int mode, input int limit);
    n = 0;
    while (hit(mode) !== 1'b1 && n < limit) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic stop_pulse();
    ev_drv.stop = 1'b1;
    @(negedge mclk);
    ev_drv.stop = 1'b0;
    @(negedge mclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 31000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    cfg = '0;
    cfg.change_pol = pump_pkg::POL_DEFAULT;
    cfg.change_hours = pump_pkg::CHANGE_H_DEFAULT;
    cfg.n_drives = 3'h3;
    cfg.upper_band = pump_pkg::UB_DEFAULT;
    cfg.lower_band = pump_pkg::LB_DEFAULT;
    cfg.pre_add_master_speed_pct = pump_pkg::TRANS_DEFAULT;
    spd = '{16'h0064, 16'h044c, 16'h01f4};
    ev_drv = '0;
    repeat (16) @(negedge mclk);
    cmp_bit(stat == '0, 1'b1);
    rst_n = 1'b1;
    ev_drv.drive_run = 1'b1;
    @(negedge mclk);
    foreach (rows[i]) begin
      cfg.pre_add_master_speed_pct = rows[i].pct;
      spd.master_speed = 16'h041a;
      wait_for(0, 20);
      cmp_val(stat.speed_req, rows[i].exp);
      spd.master_speed = 16'h01f4;
      stop_pulse();
      cmp_val(16'(stat.relay), 16'h0000);
      $display("row %0d done", i);
    end
    cfg.start_delay = 10'h003;
    cfg.pre_add_master_speed_pct = pump_pkg::TRANS_DEFAULT;
    spd.master_speed = 16'h041a;
    repeat (7) @(negedge mclk);
    cmp_bit(stat.slow_req, 1'b0);
    spd.master_speed = 16'h01f4;
    repeat (2) @(negedge mclk);
    spd.master_speed = 16'h041a;
    wait_for(0, 30);
    cmp_bit(n >= 9 && n <= 16, 1'b1);
    spd.master_speed = 16'h02bc;
    wait_for(1, 5);
    cmp_bit(stat.pid_off, 1'b1);
    cmp_val(16'($countones(stat.relay)), 16'h0001);
    $display("delayed add done");
    cfg.stop_delay = 10'h002;
    spd.master_speed = 16'h0096;
    repeat (4) @(negedge mclk);
    cmp_bit(hit(1), 1'b1);
    wait_for(2, 20);
    cmp_bit(hit(2), 1'b1);
    $display("delayed stop done");
    cfg.start_delay = 10'h3e7;
    cfg.stop_delay = 10'h3e7;
    cfg.upper_limit = 7'h05;
    cfg.lower_limit = 7'h03;
    cfg.pre_add_master_speed_pct = pump_pkg::PCT_FULL;
    spd.master_speed = 16'h0438;
    wait_for(1, 4);
    cmp_bit(hit(1), 1'b1);
    cmp_bit(stat.slow_req, 1'b0);
    spd.master_speed = 16'h0078;
    wait_for(2, 4);
    cmp_bit(hit(2), 1'b1);
    $display("band limits done");
    spd.master_speed = 16'h01f4;
    ev_drv.fb_used = 1'b1;
    fail_mask = 6'h01;
    repeat (4) @(negedge mclk);
    cmp_val(16'(stat.master), 16'h0000);
    old_master = stat.master;
    cfg.pump_sel = pump_pkg::SEL_ALT;
    wait_for(4, 4);
    cmp_bit(hit(4), 1'b1);
    fail_mask = 6'h00;
    $display("feedback swap done");
    cfg.change_hours = pump_pkg::CHANGE_H_MIN;
    old_master = stat.master;
    wait_for(3, 14500);
    cmp_bit(stat.change_due, 1'b1);
    cmp_val(16'(stat.master), 16'(old_master));
    stop_pulse();
    cmp_bit(hit(4), 1'b1);
    cmp_bit(stat.change_due, 1'b0);
    old_master = stat.master;
    cfg.change_pol = pump_pkg::POL_TIMER;
    wait_for(4, 14500);
    cmp_bit(hit(4), 1'b1);
    cmp_bit(n > 14000, 1'b1);
    cmp_bit(stat.change_due, 1'b0);
    $display("rotation done");
    ce = 1'b0;
    rt_snap = run_secs[stat.master];
    repeat (8) @(negedge mclk);
    cmp_val(run_secs[stat.master][15:0], rt_snap[15:0]);
    ce = 1'b1;
    repeat (8) @(negedge mclk);
    cmp_val(run_secs[stat.master][15:0], rt_snap[15:0] + 16'h0002);
    rt_clear = 6'h3f;
    @(negedge mclk);
    rt_clear = 6'h00;
    cmp_val(run_secs[stat.master][15:0], 16'h0000);
    $display("run meter done");
    rst_n = 1'b0;
    @(negedge mclk);
    cmp_bit(stat == '0, 1'b1);
    rst_n = 1'b1;
    $display("second reset done");
    report_and_stop();
  end
endmodule // pump_stager_bench
bind pump_stager pump_stager_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (.mclk(mclk), .rst_n(rst_n), .ce(ce),
  .cfg(cfg), .spd(spd), .ev(ev), .rt_clear(rt_clear), .stat(stat), .run_secs(run_secs));
`default_nettype wire
